// *** rtl/tone_control_register_bank.sv ***
// Tone control register bank with woofer/tweeter crossover filters.
// Assumes an AXI4-Lite master and a signed sample stream on aclk.
//
// Notes on behaviour
// - Band selector bits 10:8, seven bands, resets zero
// - Gain bits 5:0, half-dB steps, 0x18 is 0dB
// - Loudness cutoff bits 6:5, four codes, resets 00b
// - Loudness level bits 4:0, 1dB steps, resets zero
// - Low crossover bits 13:8, 50Hz plus 10Hz/step
// - Woofer output low-passed at low crossover
// - Reset loads 0x0018 equalizer, 0x0000 loudness
// - High crossover bits 5:0 drives tweeter high-pass
//
// Chosen here: register access over AXI4-Lite.
module tone_control_register_bank
   import tone_ctrl_pkg::*;
#(
   parameter int SAMPLE_W  = 24,
   parameter int SAMPLE_HZ = 48000
)(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // AXI4-Lite write address
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic [2:0]           s_axi_awprot,
   input  wire logic                 s_axi_awvalid,
   output      logic                 s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output      logic                 s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]           s_axi_bresp,
   output      logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic [2:0]           s_axi_arprot,
   input  wire logic                 s_axi_arvalid,
   output      logic                 s_axi_arready,
   // AXI4-Lite read data
   output      logic [31:0]          s_axi_rdata,
   output      logic [1:0]           s_axi_rresp,
   output      logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Settings to the audio datapath
   output      logic [2:0]           eq_band,
   output      logic [EQ_BANDS*6-1:0] eq_gains,
   output      logic [1:0]           loud_cutoff,
   output      logic [4:0]           loud_level,
   output      logic [5:0]           xover_low,
   output      logic [5:0]           xover_high,
   // Sample stream in and crossover outputs
   input  wire logic signed [SAMPLE_W-1:0] sample_in,
   input  wire logic                 sample_valid,
   output      logic signed [SAMPLE_W-1:0] woofer_out,
   output      logic signed [SAMPLE_W-1:0] tweeter_out,
   output      logic                 out_valid
);

   localparam int ACC_W = SAMPLE_W + 16;

   function automatic reg_sel_t decode(input logic [11:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      case (addr)
         ADDR_EQ:    sel = SEL_EQ;
         ADDR_LOUD:  sel = SEL_LOUD;
         ADDR_XOVER: sel = SEL_XOVER;
         default:    sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   // Coefficient of a first-order section, Q16, for a crossover code
   function automatic logic [15:0] xover_alpha(input logic [5:0] code);
      logic [31:0] hz;
      logic [31:0] fs;
      hz = XOVER_BASE_HZ + 32'(code) * XOVER_STEP_HZ;
      fs = 32'(SAMPLE_HZ);
      return 16'((hz * ALPHA_SCALE) / fs);
   endfunction

   // Register state
   logic [2:0]  eq_band_ff;
   logic [5:0]  gain_ff [EQ_BANDS];
   logic [1:0]  loud_cut_ff;
   logic [4:0]  loud_lvl_ff;
   logic [5:0]  xo_low_ff;
   logic [5:0]  xo_high_ff;

   // Write channel state
   logic        awready_ff;
   logic        wready_ff;
   logic        aw_held_ff;
   logic        w_held_ff;
   logic [11:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;

   // Read channel state
   rd_state_t   rd_state_ff;
   logic        arready_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;

   logic        commit;
   reg_sel_t    wsel;
   logic [2:0]  nxt_band;

   // Both halves of a write must be held, and the last answer taken
   assign commit = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wsel   = decode(awaddr_ff);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_ff <= 1'b1;
         aw_held_ff <= 1'b0;
         awaddr_ff  <= 12'h000;
      end
      else if (s_axi_awvalid && awready_ff)
      begin
         awready_ff <= 1'b0;
         aw_held_ff <= 1'b1;
         awaddr_ff  <= s_axi_awaddr;
      end
      else if (commit)
      begin
         awready_ff <= 1'b1;
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_ff <= 1'b1;
         w_held_ff <= 1'b0;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
      end
      else if (s_axi_wvalid && wready_ff)
      begin
         wready_ff <= 1'b0;
         w_held_ff <= 1'b1;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end
      else if (commit)
      begin
         wready_ff <= 1'b1;
         w_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end
      else if (commit)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
      begin
         bvalid_ff <= 1'b0;
      end
   end

   // Band 7 selects nothing, so such a write keeps the old band
   always_comb
   begin
      nxt_band = eq_band_ff;
      if (wstrb_ff[1] && wdata_ff[EQ_BAND_LSB +: 3] <= EQ_BAND_LAST)
      begin
         nxt_band = wdata_ff[EQ_BAND_LSB +: 3];
      end
   end

   // Reserved bits are dropped; software is expected to write them zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         eq_band_ff <= EQ_BAND_RST;
      end
      else if (commit && wsel == SEL_EQ)
      begin
         eq_band_ff <= nxt_band;
      end
   end

   // One gain per band; a write only touches the band selected after it (nxt_band), the old band when it names band 7
   for (genvar b = 0; b < EQ_BANDS; b++)
   begin : g_band
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            gain_ff[b] <= EQ_GAIN_0DB;
         end
         else if (commit && wsel == SEL_EQ && wstrb_ff[0] && nxt_band == 3'(b))
         begin
            gain_ff[b] <= wdata_ff[EQ_GAIN_LSB +: 6];
         end
      end
      assign eq_gains[b*6 +: 6] = gain_ff[b];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         loud_cut_ff <= LD_CUT_RST;
         loud_lvl_ff <= LD_LVL_RST;
      end
      else if (commit && wsel == SEL_LOUD && wstrb_ff[0])
      begin
         loud_cut_ff <= wdata_ff[LD_CUT_LSB +: 2];
         loud_lvl_ff <= wdata_ff[LD_LVL_LSB +: 5];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         xo_low_ff  <= XO_LOW_RST;
         xo_high_ff <= XO_HIGH_RST;
      end
      else if (commit && wsel == SEL_XOVER)
      begin
         if (wstrb_ff[1])
         begin
            xo_low_ff <= wdata_ff[XO_LOW_LSB +: 6];
         end
         if (wstrb_ff[0])
         begin
            xo_high_ff <= wdata_ff[XO_HIGH_LSB +: 6];
         end
      end
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_ff <= RD_IDLE;
         arready_ff  <= 1'b1;
         rvalid_ff   <= 1'b0;
         rdata_ff    <= 32'h0000_0000;
         rresp_ff    <= RESP_OKAY;
      end
      else
      begin
         case (rd_state_ff)
            RD_IDLE:
            begin
               if (s_axi_arvalid)
               begin
                  rd_state_ff <= RD_RESP;
                  arready_ff  <= 1'b0;
                  rvalid_ff   <= 1'b1;
                  rresp_ff    <= RESP_OKAY;
                  case (decode(s_axi_araddr))
                     SEL_EQ:
                        rdata_ff <= {21'h0, eq_band_ff, 2'h0, gain_ff[eq_band_ff]};
                     SEL_LOUD:
                        rdata_ff <= {25'h0, loud_cut_ff, loud_lvl_ff};
                     SEL_XOVER:
                        rdata_ff <= {18'h0, xo_low_ff, 2'h0, xo_high_ff};
                     default:
                     begin
                        rdata_ff <= 32'h0000_0000;
                        rresp_ff <= RESP_SLVERR;
                     end
                  endcase
               end
            end
            RD_RESP:
            begin
               if (s_axi_rready)
               begin
                  rd_state_ff <= RD_IDLE;
                  arready_ff  <= 1'b1;
                  rvalid_ff   <= 1'b0;
               end
            end
            default:
            begin
               rd_state_ff <= RD_IDLE;
               arready_ff  <= 1'b1;
               rvalid_ff   <= 1'b0;
            end
         endcase
      end
   end

   // Crossover: first-order sections, a trade of slope for area
   logic [15:0]              lo_alpha_ff;
   logic [15:0]              hi_alpha_ff;
   logic signed [ACC_W-1:0]  lo_acc_ff;
   logic signed [ACC_W-1:0]  hi_acc_ff;
   logic signed [ACC_W:0]    lo_err;
   logic signed [ACC_W:0]    hi_err;
   logic signed [ACC_W+17:0] lo_prod;
   logic signed [ACC_W+17:0] hi_prod;
   logic signed [ACC_W-1:0]  nxt_lo_acc;
   logic signed [ACC_W-1:0]  nxt_hi_acc;
   logic signed [ACC_W-1:0]  x_scaled;
   logic signed [SAMPLE_W-1:0] woofer_ff;
   logic signed [SAMPLE_W-1:0] tweeter_ff;
   logic                     out_valid_ff;

   // Coefficients registered to keep the divider off the sample path
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lo_alpha_ff <= xover_alpha(XO_LOW_RST);
         hi_alpha_ff <= xover_alpha(XO_HIGH_RST);
      end
      else
      begin
         lo_alpha_ff <= xover_alpha(xo_low_ff);
         hi_alpha_ff <= xover_alpha(xo_high_ff);
      end
   end

   always_comb
   begin
      x_scaled   = {sample_in, 16'h0000};
      lo_err     = (ACC_W+1)'(x_scaled) - (ACC_W+1)'(lo_acc_ff);
      hi_err     = (ACC_W+1)'(x_scaled) - (ACC_W+1)'(hi_acc_ff);
      lo_prod    = (ACC_W+18)'(lo_err * $signed({1'b0, lo_alpha_ff}));
      hi_prod    = (ACC_W+18)'(hi_err * $signed({1'b0, hi_alpha_ff}));
      nxt_lo_acc = lo_acc_ff + ACC_W'(lo_prod >>> 16);
      nxt_hi_acc = hi_acc_ff + ACC_W'(hi_prod >>> 16);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lo_acc_ff    <= '0;
         hi_acc_ff    <= '0;
         woofer_ff    <= '0;
         tweeter_ff   <= '0;
         out_valid_ff <= 1'b0;
      end
      else
      begin
         out_valid_ff <= sample_valid;
         if (sample_valid)
         begin
            lo_acc_ff  <= nxt_lo_acc;
            hi_acc_ff  <= nxt_hi_acc;
            woofer_ff  <= nxt_lo_acc[ACC_W-1:16];
            // High-pass is the input less its own low-pass
            tweeter_ff <= SAMPLE_W'(sample_in - nxt_hi_acc[ACC_W-1:16]);
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign eq_band       = eq_band_ff;
   assign loud_cutoff   = loud_cut_ff;
   assign loud_level    = loud_lvl_ff;
   assign xover_low     = xo_low_ff;
   assign xover_high    = xo_high_ff;
   assign woofer_out    = woofer_ff;
   assign tweeter_out   = tweeter_ff;
   assign out_valid     = out_valid_ff;

endmodule // tone_control_register_bank

// *** rtl/tone_ctrl_pkg.sv ***
// Shared constants of the tone control register bank.
// Assumes a 32-bit AXI4-Lite slave with 12-bit byte addresses.
package tone_ctrl_pkg;

   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_EQ       = 12'h107;
   localparam logic [11:0] IDX_LOUD     = 12'h108;
   localparam logic [11:0] IDX_XOVER    = 12'h109;
   localparam logic [11:0] ADDR_EQ      = 12'(IDX_EQ << 2);
   localparam logic [11:0] ADDR_LOUD    = 12'(IDX_LOUD << 2);
   localparam logic [11:0] ADDR_XOVER   = 12'(IDX_XOVER << 2);

   // Field positions
   localparam int EQ_BAND_LSB   = 8;
   localparam int EQ_GAIN_LSB   = 0;
   localparam int LD_CUT_LSB    = 5;
   localparam int LD_LVL_LSB    = 0;
   localparam int XO_LOW_LSB    = 8;
   localparam int XO_HIGH_LSB   = 0;

   // Equalizer bands and codes
   localparam int          EQ_BANDS       = 7;
   localparam logic [2:0]  EQ_BAND_LAST   = 3'h6;
   localparam logic [5:0]  EQ_GAIN_0DB    = 6'h18;
   localparam logic [5:0]  EQ_GAIN_MIN    = 6'h30;

   // Values after reset
   localparam logic [2:0]  EQ_BAND_RST    = 3'h0;
   localparam logic [1:0]  LD_CUT_RST     = 2'h0;
   localparam logic [4:0]  LD_LVL_RST     = 5'h00;
   localparam logic [5:0]  XO_LOW_RST     = 6'h05;
   localparam logic [5:0]  XO_HIGH_RST    = 6'h05;

   // Crossover code to frequency
   localparam logic [31:0] XOVER_BASE_HZ  = 32'h0000_0032;
   localparam logic [31:0] XOVER_STEP_HZ  = 32'h0000_000A;
   // Two pi times 2^16, for first-order filter coefficients
   localparam logic [31:0] ALPHA_SCALE    = 32'h0006_487F;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [1:0] {SEL_NONE, SEL_EQ, SEL_LOUD, SEL_XOVER} reg_sel_t;
   typedef enum logic {RD_IDLE = 1'b0, RD_RESP = 1'b1} rd_state_t;

endpackage : tone_ctrl_pkg

// *** dv/tone_ctrl_asserts.sv ***
// Port-level assertions for the tone control register bank.
// Bound to the top module; sees only its ports, one clock domain.
module tone_ctrl_asserts
   import tone_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic                  aclk,
   input wire logic                  aresetn,
   // Bus handshakes
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic [31:0]           s_axi_rdata,
   // Settings and stream
   input wire logic [2:0]            eq_band,
   input wire logic [EQ_BANDS*6-1:0] eq_gains,
   input wire logic [1:0]            loud_cutoff,
   input wire logic [4:0]            loud_level,
   input wire logic [5:0]            xover_low,
   input wire logic [5:0]            xover_high,
   input wire logic                  sample_valid,
   input wire logic                  out_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reset_eq_loud : assert property (disable iff (1'b0) !aresetn |=>
      eq_band == 3'h0 && eq_gains[5:0] == 6'h18 && loud_cutoff == 2'h0 && loud_level == 5'h00)
      else $error("equalizer or loudness default wrong");
   a_reset_xover : assert property (disable iff (1'b0) !aresetn |=>
      xover_low == 6'h05 && xover_high == 6'h05)
      else $error("crossover default wrong");
   a_band_range : assert property (eq_band <= 3'h6)
      else $error("band selector out of range");
   a_write_commit : assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write not answered in time");
   a_settings_on_commit : assert property (!$stable({eq_band, eq_gains, loud_cutoff,
      loud_level, xover_low, xover_high}) |-> $rose(s_axi_bvalid))
      else $error("setting changed without a write");
   a_read_answer : assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_read_hold : assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_stream_pulse : assert property (sample_valid |=> out_valid)
      else $error("no filtered sample after input");
   a_stream_quiet : assert property (!sample_valid |=> !out_valid)
      else $error("filtered sample without input");

   c_top_band : cover property ($rose(s_axi_bvalid) && eq_band == 3'h6);
   c_read : cover property (s_axi_rvalid && s_axi_rready);
   c_sample : cover property (out_valid);
endmodule // tone_ctrl_asserts

bind tone_control_register_bank tone_ctrl_asserts tone_ctrl_asserts_inst (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .eq_band,
   .eq_gains, .loud_cutoff, .loud_level, .xover_low, .xover_high, .sample_valid, .out_valid);

// *** dv/testbench.sv ***
// Self-checking bench for the tone control register bank.
// Drives the AXI4-Lite slave and the sample stream directly.
module testbench
   import tone_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic               aclk = 1'b0, aresetn = 1'b0;
   logic [11:0]        s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0]         s_axi_awprot = '0, s_axi_arprot = '0;
   logic [31:0]        s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]         s_axi_wstrb = 4'hF;
   logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic               s_axi_arvalid = 0, s_axi_rready = 0, sample_valid = 0;
   logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]         s_axi_bresp, s_axi_rresp, loud_cutoff;
   logic [2:0]         eq_band, band_m;
   logic [41:0]        eq_gains;
   logic [6:0][5:0]    gain_m;
   logic [4:0]         loud_level, lv;
   logic [5:0]         xover_low, xover_high, lo, hi;
   logic signed [23:0] sample_in = '0, woofer_out, tweeter_out;
   logic               out_valid;
   int                 n_errors = 0, n_tests = 0, seed = 32'hc831, v = 32'h0010_0000;

   tone_control_register_bank tone_control_register_bank_inst (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eq_band, .eq_gains, .loud_cutoff,
      .loud_level, .xover_low, .xover_high, .sample_in, .sample_valid, .woofer_out,
      .tweeter_out, .out_valid);

   initial
   begin
      forever #25 aclk = ~aclk;
   end

   // Reserved bits stay zero by construction of these words
   function automatic logic [31:0] eq_word(logic [2:0] b, logic [5:0] g);
      return {21'h0, b, 2'h0, g};
   endfunction
   function automatic logic [31:0] loud_word(logic [1:0] c, logic [4:0] l);
      return {25'h0, c, l};
   endfunction
   function automatic logic [31:0] xo_word(logic [5:0] l, logic [5:0] h);
      return {18'h0, l, 2'h0, h};
   endfunction
   function automatic int mag(int x);
      return (x < 0) ? -x : x;
   endfunction

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", 64'(er), 64'(s_axi_bresp));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", 64'(ed), 64'(s_axi_rdata));
      chk("rresp", 64'(er), 64'(s_axi_rresp));
   endtask

   task automatic eq_set(input logic [2:0] b, input logic [5:0] g);
      wr(ADDR_EQ, eq_word(b, g), RESP_OKAY);
      // Band lane only lands when its byte strobe is set
      if (b != 3'h7 && s_axi_wstrb[1])
         band_m = b;
      gain_m[band_m] = g;
      rd(ADDR_EQ, eq_word(band_m, gain_m[band_m]), RESP_OKAY);
      chk("eq_band", 64'(band_m), 64'(eq_band));
      chk("eq_gains", 64'(gain_m), 64'(eq_gains));
   endtask

   task automatic defaults();
      band_m = 3'h0;
      gain_m = {7{6'h18}};
      rd(ADDR_EQ, 32'h0000_0018, RESP_OKAY);
      rd(ADDR_LOUD, 32'h0000_0000, RESP_OKAY);
      rd(ADDR_XOVER, 32'h0000_0505, RESP_OKAY);
      chk("eq_gains", 64'(gain_m), 64'(eq_gains));
      $display("test defaults done");
   endtask

   // Back-to-back samples, long enough for the filters to settle
   task automatic stream(input bit alt);
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge aclk);
         sample_in <= (alt && i[0]) ? 24'(-v) : 24'(v);
         sample_valid <= 1'b1;
      end
      @(posedge aclk);
      sample_valid <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge aclk);
      n_errors++;
      $display("FAIL watchdog expected finish seen timeout");
      final_report();
   end

   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      defaults();
      eq_set(3'h6, 6'h30);
      eq_set(3'h0, 6'h00);
      eq_set(3'h7, 6'h0A);
      repeat (20) eq_set(3'($unsigned($random(seed)) % 7), 6'($unsigned($random(seed)) % 49));
      s_axi_wstrb <= 4'h1;
      eq_set((band_m == 3'h3) ? 3'h2 : 3'h3, 6'h26);
      s_axi_wstrb <= 4'hF;
      $display("test equalizer done");
      for (int c = 0; c < 4; c++)
      begin
         lv = (c == 3) ? 5'h0F : 5'($unsigned($random(seed)) % 16);
         wr(ADDR_LOUD, loud_word(2'(c), lv), RESP_OKAY);
         rd(ADDR_LOUD, loud_word(2'(c), lv), RESP_OKAY);
         chk("loud_cutoff", 64'(c), 64'(loud_cutoff));
         chk("loud_level", 64'(lv), 64'(loud_level));
      end
      $display("test loudness done");
      for (int i = 0; i < 3; i++)
      begin
         lo = (i == 0) ? 6'h00 : (i == 1) ? 6'h2D : 6'($unsigned($random(seed)) % 46);
         hi = 6'($unsigned($random(seed)) % 61);
         wr(ADDR_XOVER, xo_word(lo, hi), RESP_OKAY);
         rd(ADDR_XOVER, xo_word(lo, hi), RESP_OKAY);
         chk("xover_low", 64'(lo), 64'(xover_low));
         chk("xover_high", 64'(hi), 64'(xover_high));
      end
      wr(12'h428, 32'h0000_0001, RESP_SLVERR);
      rd(12'h428, 32'h0000_0000, RESP_SLVERR);
      rd(ADDR_EQ, eq_word(band_m, gain_m[band_m]), RESP_OKAY);
      $display("test crossover done");
      wr(ADDR_XOVER, xo_word(6'h05, 6'h3C), RESP_OKAY);
      stream(1'b0);
      chk("woofer_dc", 64'h1, 64'(mag(int'(woofer_out) - v) < v / 64));
      chk("tweeter_dc", 64'h1, 64'(mag(int'(tweeter_out)) < v / 64));
      stream(1'b1);
      chk("woofer_hf", 64'h1, 64'(mag(int'(woofer_out)) < v / 8));
      chk("tweeter_hf", 64'h1, 64'(mag(int'(tweeter_out)) > v / 2));
      $display("test stream done");
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      defaults();
      final_report();
   end
endmodule // testbench
